// file: core/cpmb_bridge.sv
// Purpose: nibble cell ports with control cell filter and manager bus master
// Assumes: link clocks far slower than ref_clk_in; controller clock period per header
// Notes:   link inputs taken on link rise, outputs launched on link fall
// What this block does
// RQ1 - four-bit ports, sampled on own clock rise
// RQ2 - receive clock out derived from receive clock
// RQ3 - receive frame mark one cycle before nibble0
// RQ4 - transmit clock out derived from transmit clock
// RQ5 - transmit frame mark one cycle before nibble0
// RQ6 - header nibble order GFC VPI VCI PTI HEC
// RQ7 - payload from nibble 10, 106 nibbles total
// RQ8 - exchange: load, command, poll, read back
// RQ9 - next command only after acknowledge bit seen
// RQ10 - poll status with select low, direction high
// RQ11 - wait for acknowledge without any timeout
// RQ12 - direction high reads, low writes
// RQ13 - select low command, high data registers
// RQ14 - controller drives data only strobe low reading
// RQ15 - write data held around strobe rising edge
// RQ16 - data registers one per strobe, ascending
// RQ17 - only needed steps and register count
// RQ18 - direction and strobe hold after strobe rise
// RQ19 - control cell: zero VPI, VCI equals address
// RQ20 - count nibbles, forward non-control cells unchanged
// RQ21 - sequential master, no command while busy
`include "cpmb_params.svh"
module cpmb_bridge
    import cpmb_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       rx_port_clock_in,
    input  wire logic [3:0] rx_cell_nibble_in,
    input  wire logic       rx_frame_mark_in,
    input  wire logic       tx_port_clock_in,
    input  wire logic [3:0] tx_cell_nibble_in,
    input  wire logic       tx_frame_mark_in,
    input  wire logic [7:0] switch_address_pins_in,
    input  wire logic [7:0] mgr_data_bus_in,
    output logic            rx_port_clock_out,
    output logic [3:0]      rx_cell_nibble_out,
    output logic            rx_frame_mark_out,
    output logic            tx_port_clock_out,
    output logic [3:0]      tx_cell_nibble_out,
    output logic            tx_frame_mark_out,
    output logic            reg_select_line_out,
    output logic            direction_line_out,
    output logic            mgr_strobe_out,
    output logic [7:0]      mgr_data_bus_out,
    output logic            mgr_data_bus_oe_out,
    output logic [7:0]      mgr_rd_data_out,
    output logic            mgr_rd_valid_out,
    output logic            mgr_done_out,
    output logic            mgr_busy_out
);
    cpmb_state_s q;
    cpmb_state_s d;
    logic        rx_rise;
    logic        rx_fall;
    logic        tx_rise;
    logic        tx_fall;

    // link clock edges, seen only from second and third flops
    assign rx_rise = q.rxc[1] & ~q.rxc[2];
    assign rx_fall = ~q.rxc[1] & q.rxc[2];
    assign tx_rise = q.txc[1] & ~q.txc[2];
    assign tx_fall = ~q.txc[1] & q.txc[2];

    // next state of the whole block except the check helper ack_seen_q
    always_comb begin
        cpmb_nib_s  smp;
        logic       go;
        logic       fwd_n;
        logic [5:0] byt;
        smp = q.rxi2;
        go = 1'b0;
        fwd_n = q.fwd;
        byt = 6'd0;
        d = q;
        d.rd_valid = 1'b0;
        d.done = 1'b0;
        // RQ1 two-flop input sampling
        d.rxc = {q.rxc[1:0], rx_port_clock_in};
        d.txc = {q.txc[1:0], tx_port_clock_in};
        d.rxi1 = '{mark: rx_frame_mark_in, nib: rx_cell_nibble_in};
        d.rxi2 = q.rxi1;
        d.txi1 = '{mark: tx_frame_mark_in, nib: tx_cell_nibble_in};
        d.txi2 = q.txi1;
        d.swa1 = switch_address_pins_in;
        d.swa2 = q.swa1;
        d.mdi1 = mgr_data_bus_in;
        d.mdi2 = q.mdi1;
        // RQ19 catch switch address after reset release
        if (q.swa_cnt != 2'd3) begin
            d.swa_cnt = q.swa_cnt + 2'd1;
            d.swa = q.swa2;
        end
        // receive side: delay line, delineation, filter
        if (rx_rise) begin
            d.dly = {q.dly[6:0], smp};
            // RQ3 mark precedes nibble zero
            if (smp.mark) begin
                d.rx_act = 1'b1;
                d.rx_cnt = 7'd0;
                d.hdr_ok = 1'b1;
            end else if (q.rx_act) begin
                // RQ20 count through nibble 105
                if (q.rx_cnt == `CPMB_NIB_LAST) begin
                    d.rx_act = 1'b0;
                end else begin
                    d.rx_cnt = q.rx_cnt + 7'd1;
                end
                // RQ6 VPI and upper VCI nibbles
                if (q.rx_cnt >= 7'd1 && q.rx_cnt <= `CPMB_NIB_VCI_HI && smp.nib != 4'h0) begin
                    d.hdr_ok = 1'b0;
                end
                // RQ19 lower VCI byte against address
                if (q.rx_cnt == `CPMB_NIB_VCI_MID && smp.nib != q.swa[7:4]) begin
                    d.hdr_ok = 1'b0;
                end
                if (q.rx_cnt == `CPMB_NIB_VCI_LO) begin
                    d.rx_ctl = q.hdr_ok & (smp.nib == q.swa[3:0]);
                end
                // RQ7 payload bytes, high nibble first, frozen while busy
                if (q.rx_ctl && q.ms == M_IDLE && q.rx_cnt >= `CPMB_NIB_PAYLOAD) begin
                    if (!q.rx_cnt[0]) begin
                        d.hi = smp.nib;
                    end else begin
                        byt = q.rx_cnt[6:1] - 6'd5;
                        if (byt == `CPMB_PL_MCMD) begin
                            d.mcmd = {q.hi, smp.nib};
                        end else if (byt == `CPMB_PL_CCMD) begin
                            d.ccmd = {q.hi, smp.nib};
                        end else if (byt == `CPMB_PL_COUNT) begin
                            d.cnt = ({q.hi, smp.nib} > 8'd13) ? `CPMB_NDATA : smp.nib;
                        end else if (byt >= `CPMB_PL_DATA0 && byt < 6'd17) begin
                            d.data[4'(byt - `CPMB_PL_DATA0)] = {q.hi, smp.nib};
                        end
                    end
                end
                // RQ21 start only when master is idle
                if (q.rx_cnt == `CPMB_NIB_LAST && q.rx_ctl && q.ms == M_IDLE) begin
                    go = 1'b1;
                end
            end
            // RQ20 drop control cells, pass others
            if (q.dly[`CPMB_DLY_LAST].mark) begin
                fwd_n = ~q.rx_ctl;
            end
            d.fwd = fwd_n;
            d.stg = fwd_n ? q.dly[`CPMB_DLY_LAST] : '0;
        end
        // RQ2 launch receive outputs on link fall
        if (rx_fall) begin
            d.rxo = q.stg;
        end
        // RQ5 transmit path passes through in step
        if (tx_rise) begin
            d.tstg = q.txi2;
        end
        if (tx_fall) begin
            d.txo = q.tstg;
        end
        // RQ8 manager bus master sequence
        case (q.ms)
            M_IDLE: begin
                d.oe = 1'b0;
                d.dir = 1'b1;
                d.sel = 1'b0;
                d.strb = 1'b1;
                if (go) begin
                    d.idx = 4'd0;
                    // RQ17 load step only for writes with data
                    d.ph = (!d.mcmd[`CPMB_RDOP_BIT] && d.cnt != 4'd0) ? P_LOAD : P_CMD;
                    d.ms = M_SETUP;
                    d.wcnt = 5'(`CPMB_DIRH_CYC - 1);
                end
            end
            M_SETUP: begin
                if (q.wcnt == 5'd0) begin
                    d.ms = M_LOW;
                    d.strb = 1'b0;
                    d.wcnt = 5'(`CPMB_LO_CYC - 1);
                end else begin
                    d.wcnt = q.wcnt - 5'd1;
                end
            end
            M_LOW: begin
                if (q.wcnt == 5'd0) begin
                    // RQ14 sample while controller drives
                    d.rdb = q.mdi2;
                    d.strb = 1'b1;
                    d.ms = M_HOLD;
                    d.wcnt = 5'(`CPMB_HOLD_CYC - 1);
                end else begin
                    d.wcnt = q.wcnt - 5'd1;
                end
            end
            M_HOLD: begin
                // RQ18 hold lines after strobe rise
                if (q.wcnt != 5'd0) begin
                    d.wcnt = q.wcnt - 5'd1;
                end else begin
                    d.ms = M_SETUP;
                    d.wcnt = 5'(`CPMB_DIRH_CYC - 1);
                    case (q.ph)
                        P_LOAD: begin
                            // RQ16 ascending register accesses
                            if (q.idx + 4'd1 < q.cnt) begin
                                d.idx = q.idx + 4'd1;
                            end else begin
                                d.ph = P_CMD;
                            end
                        end
                        P_CMD: begin
                            d.ph = P_POLL;
                        end
                        P_POLL: begin
                            // RQ9 proceed only on acknowledge
                            // RQ11 poll indefinitely, no timeout
                            if (q.rdb[`CPMB_ACK_BIT]) begin
                                d.idx = 4'd0;
                                if (q.mcmd[`CPMB_RDOP_BIT] && q.cnt != 4'd0) begin
                                    d.ph = P_READ;
                                end else begin
                                    d.ms = M_IDLE;
                                    d.done = 1'b1;
                                end
                            end
                        end
                        P_READ: begin
                            d.rd_out = q.rdb;
                            d.rd_valid = 1'b1;
                            if (q.idx + 4'd1 < q.cnt) begin
                                d.idx = q.idx + 4'd1;
                            end else begin
                                d.ms = M_IDLE;
                                d.done = 1'b1;
                            end
                        end
                    endcase
                end
            end
        endcase
        // RQ10 RQ12 RQ13 line levels for the coming access
        if (d.ms == M_SETUP) begin
            d.sel = (d.ph == P_LOAD) || (d.ph == P_READ);
            d.dir = (d.ph == P_POLL) || (d.ph == P_READ);
            // RQ15 drive data only while writing
            d.oe = ~d.dir;
            d.mgr_data_bus = (d.ph == P_CMD) ? q.ccmd : q.data[d.idx];
        end
        // RQ21 busy flag kept in a flop
        d.busy = (d.ms != M_IDLE);
    end

    // state register
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= '0;
            q.strb <= 1'b1;
            q.dir <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from state flops
    assign rx_port_clock_out = q.rxc[2];
    assign rx_cell_nibble_out = q.rxo.nib;
    assign rx_frame_mark_out = q.rxo.mark;
    // RQ4 transmit clock forwarded
    assign tx_port_clock_out = q.txc[2];
    assign tx_cell_nibble_out = q.txo.nib;
    assign tx_frame_mark_out = q.txo.mark;
    assign reg_select_line_out = q.sel;
    assign direction_line_out = q.dir;
    assign mgr_strobe_out = q.strb;
    assign mgr_data_bus_out = q.mgr_data_bus;
    assign mgr_data_bus_oe_out = q.oe;
    assign mgr_rd_data_out = q.rd_out;
    assign mgr_rd_valid_out = q.rd_valid;
    assign mgr_done_out = q.done;
    assign mgr_busy_out = q.busy;

    // acknowledge-seen helper for the checks below
    logic ack_seen_q;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_seen_q <= 1'b1;
        end else if (q.ms == M_HOLD && q.ph == P_POLL && q.rdb[`CPMB_ACK_BIT]) begin
            ack_seen_q <= 1'b1;
        end else if (!q.strb && q.ph == P_CMD) begin
            ack_seen_q <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    property p_rx_mark_short;
        $rose(rx_frame_mark_out) |-> ##[1:20] $fell(rx_frame_mark_out);
    endproperty
    a_rx_mark_short: assert property (p_rx_mark_short) // RQ3
        else $error("receive frame mark too long");
    property p_tx_mark_short;
        $rose(tx_frame_mark_out) |-> ##[1:20] $fell(tx_frame_mark_out);
    endproperty
    a_tx_mark_short: assert property (p_tx_mark_short) // RQ5
        else $error("transmit frame mark too long");
    property p_no_ctl_fwd;
        (rx_rise && q.dly[`CPMB_DLY_LAST].mark && q.rx_ctl) |=> !q.stg.mark;
    endproperty
    a_no_ctl_fwd: assert property (p_no_ctl_fwd) // RQ20
        else $error("control cell forwarded");
    property p_write_dir;
        mgr_data_bus_oe_out |-> !direction_line_out;
    endproperty
    a_write_dir: assert property (p_write_dir) // RQ12
        else $error("bus driven in read direction");
    property p_write_hold;
        ($rose(mgr_strobe_out) && !direction_line_out) |->
            $past(mgr_data_bus_oe_out) ##1 ($stable(mgr_data_bus_out) && mgr_data_bus_oe_out);
    endproperty
    a_write_hold: assert property (p_write_hold) // RQ15
        else $error("write data not held at strobe rise");
    property p_line_hold;
        $rose(mgr_strobe_out) |-> ##1 ($stable(direction_line_out) && $stable(reg_select_line_out))[*3];
    endproperty
    a_line_hold: assert property (p_line_hold) // RQ18
        else $error("direction or select changed too soon");
    property p_cmd_after_ack;
        ($fell(mgr_strobe_out) && q.ph == P_CMD) |-> ack_seen_q;
    endproperty
    a_cmd_after_ack: assert property (p_cmd_after_ack) // RQ9
        else $error("command issued before acknowledge");
    property p_poll_lines;
        (!mgr_strobe_out && q.ph == P_POLL) |-> !reg_select_line_out && direction_line_out;
    endproperty
    a_poll_lines: assert property (p_poll_lines) // RQ10
        else $error("status poll with wrong lines");
    property p_data_select;
        (!mgr_strobe_out && (q.ph == P_LOAD || q.ph == P_READ)) |-> reg_select_line_out;
    endproperty
    a_data_select: assert property (p_data_select) // RQ13
        else $error("data access without data select");
    property p_idx_bound;
        mgr_busy_out |-> (q.idx < `CPMB_NDATA) && (q.idx <= q.cnt);
    endproperty
    a_idx_bound: assert property (p_idx_bound) // RQ17
        else $error("register index past count");
    property p_cnt_bound;
        q.rx_cnt <= `CPMB_NIB_LAST;
    endproperty
    a_cnt_bound: assert property (p_cnt_bound) // RQ7
        else $error("nibble count past cell end");

    c_ctl_start: cover property (mgr_busy_out && !$past(mgr_busy_out));
    c_poll_again: cover property (q.ms == M_HOLD && q.ph == P_POLL && !q.rdb[`CPMB_ACK_BIT]);
    c_read_byte: cover property (mgr_rd_valid_out);
    c_fwd_cell: cover property ($rose(rx_frame_mark_out));
endmodule

// file: core/cpmb_params.svh
// Purpose: constants for the cell port and manager bus bridge
// Assumes: 40 MHz reference clock
// Notes:   counts derive from times by rounding up
`ifndef CPMB_PARAMS_SVH
`define CPMB_PARAMS_SVH
`define CPMB_REFCLK_NS    25
`define CPMB_SCLK_NS      50
`define CPMB_STRB_LO_NS   100
`define CPMB_DIRH_CYC     (((2 * `CPMB_SCLK_NS) + `CPMB_REFCLK_NS - 1) / `CPMB_REFCLK_NS)
`define CPMB_HOLD_CYC     (((4 * `CPMB_SCLK_NS) + `CPMB_REFCLK_NS - 1) / `CPMB_REFCLK_NS)
`define CPMB_LO_CYC       ((`CPMB_STRB_LO_NS + `CPMB_REFCLK_NS - 1) / `CPMB_REFCLK_NS)
`define CPMB_NIB_LAST     7'd105
`define CPMB_NIB_VCI_HI   7'd4
`define CPMB_NIB_VCI_MID  7'd5
`define CPMB_NIB_VCI_LO   7'd6
`define CPMB_NIB_PAYLOAD  7'd10
`define CPMB_PL_MCMD      6'd0
`define CPMB_PL_CCMD      6'd1
`define CPMB_PL_COUNT     6'd3
`define CPMB_PL_DATA0     6'd4
`define CPMB_NDATA        4'd13
`define CPMB_ACK_BIT      7
`define CPMB_RDOP_BIT     0
`define CPMB_DLY_LAST     7
`endif

// file: core/cpmb_pkg.sv
// Purpose: types for the cell port and manager bus bridge
// Assumes: nothing beyond the params header
// Notes:   whole state of the top apart from ack_seen_q is one packed struct
package cpmb_pkg;
    typedef struct packed {
        logic       mark;
        logic [3:0] nib;
    } cpmb_nib_s;
    typedef enum logic [1:0] {
        M_IDLE  = 2'b00,
        M_SETUP = 2'b01,
        M_LOW   = 2'b10,
        M_HOLD  = 2'b11
    } cpmb_mstate_e;
    typedef enum logic [1:0] {
        P_LOAD = 2'b00,
        P_CMD  = 2'b01,
        P_POLL = 2'b10,
        P_READ = 2'b11
    } cpmb_phase_e;
    typedef struct packed {
        logic [2:0]       rxc;
        logic [2:0]       txc;
        cpmb_nib_s        rxi1;
        cpmb_nib_s        rxi2;
        cpmb_nib_s        txi1;
        cpmb_nib_s        txi2;
        logic [7:0]       swa1;
        logic [7:0]       swa2;
        logic [7:0]       swa;
        logic [1:0]       swa_cnt;
        cpmb_nib_s [7:0]  dly;
        logic [6:0]       rx_cnt;
        logic             rx_act;
        logic             hdr_ok;
        logic             rx_ctl;
        logic             fwd;
        cpmb_nib_s        stg;
        cpmb_nib_s        rxo;
        cpmb_nib_s        tstg;
        cpmb_nib_s        txo;
        logic [3:0]       hi;
        logic [7:0]       mcmd;
        logic [7:0]       ccmd;
        logic [3:0]       cnt;
        logic [12:0][7:0] data;
        cpmb_mstate_e     ms;
        cpmb_phase_e      ph;
        logic [3:0]       idx;
        logic [4:0]       wcnt;
        logic [7:0]       mdi1;
        logic [7:0]       mdi2;
        logic [7:0]       rdb;
        logic [7:0]       mgr_data_bus;
        logic             oe;
        logic             sel;
        logic             dir;
        logic             strb;
        logic [7:0]       rd_out;
        logic             rd_valid;
        logic             done;
        logic             busy;
    } cpmb_state_s;
endpackage

// file: verif/cell_port_and_manager_bus_bench.sv
// Purpose: self-checking bench for the cell port and manager bus bridge
// Assumes: 200 ns link clocks launched on the ref clock falling edge
// Notes:   controller model keeps the data registers and counts bus slips
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_fail++; \
    $display("MISMATCH %s expected %h got %h", nm, ex, got); end end
module cell_port_and_manager_bus_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 clk = 1'b0;
    logic                 rst_n;
    logic [1:0]           lk_clk, lk_mark, prev_c;
    logic [1:0][3:0]      lk_nib;
    logic [7:0]           swa, ack_polls, erd;
    logic [3:0]           enib;
    wire logic [1:0]      fo_clk, fo_mark;
    wire logic [1:0][3:0] fo_nib;
    wire logic [7:0]      bus, d_out, rd_d;
    wire logic            sel, dir, strb_n, oe, rd_v, done, busy;
    int                   mcnt [2] = '{-1, -1};
    int                   n_fail, cmp_count, n_done;
    logic [3:0]           expq [2][$];
    logic [7:0]           exp_regs [13];
    logic [7:0]           exp_rd [$];

    cpmb_bridge u_cpmb_bridge (
        .ref_clk_in(clk), .reset_n_in(rst_n), .switch_address_pins_in(swa),
        .rx_port_clock_in(lk_clk[0]), .rx_cell_nibble_in(lk_nib[0]),
        .rx_frame_mark_in(lk_mark[0]), .tx_port_clock_in(lk_clk[1]),
        .tx_cell_nibble_in(lk_nib[1]), .tx_frame_mark_in(lk_mark[1]),
        .mgr_data_bus_in(bus), .rx_port_clock_out(fo_clk[0]),
        .rx_cell_nibble_out(fo_nib[0]), .rx_frame_mark_out(fo_mark[0]),
        .tx_port_clock_out(fo_clk[1]), .tx_cell_nibble_out(fo_nib[1]),
        .tx_frame_mark_out(fo_mark[1]), .reg_select_line_out(sel),
        .direction_line_out(dir), .mgr_strobe_out(strb_n), .mgr_data_bus_out(d_out),
        .mgr_data_bus_oe_out(oe), .mgr_rd_data_out(rd_d), .mgr_rd_valid_out(rd_v),
        .mgr_done_out(done), .mgr_busy_out(busy)
    );
    cpmb_ctrl_model u_cpmb_ctrl_model (
        .reset_n_in(rst_n), .strobe_n_in(strb_n), .dir_in(dir), .sel_in(sel),
        .dev_data_in(d_out), .dev_oe_in(oe), .ack_polls_in(ack_polls), .bus_out(bus)
    );

    // reference clock
    always #12.5 clk = ~clk;

    // collect forwarded nibbles and read-back bytes on the falling ref edge, outputs settled
    always @(negedge clk) begin
        for (int p = 0; p < 2; p++) begin
            if (fo_clk[p] && !prev_c[p]) begin
                if (mcnt[p] >= 0) begin
                    enib = (expq[p].size() > 0) ? expq[p].pop_front() : 4'hx;
                    `CHK("frame mark", 1'b0, fo_mark[p])
                    `CHK("cell nibble", enib, fo_nib[p])
                    mcnt[p] = (mcnt[p] == 105) ? -1 : mcnt[p] + 1;
                end else if (fo_mark[p])
                    mcnt[p] = 0;
            end
        end
        prev_c <= fo_clk;
        if (done)
            n_done++;
        if (rd_v) begin
            erd = (exp_rd.size() > 0) ? exp_rd.pop_front() : 8'hxx;
            `CHK("read byte", erd, rd_d)
        end
    end

    // one link cycle: data launched with the falling link edge
    task automatic cyc(input bit p, input logic m, input logic [3:0] n);
        @(negedge clk);
        lk_clk[p] = 1'b0;
        lk_mark[p] = m;
        lk_nib[p] = n;
        repeat (4) @(negedge clk);
        lk_clk[p] = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    // send a cell: kind 0 plain, 1 address near miss, 2 control
    task automatic send(input bit p, input int kind, input logic [7:0] b0,
                        input logic [7:0] b1, input logic [7:0] b3);
        logic [3:0] c [106];
        int         n;
        n = (b3 > 13) ? 13 : int'(b3);
        for (int i = 0; i < 106; i++)
            c[i] = 4'($urandom);
        if (kind > 0) begin
            for (int i = 1; i < 5; i++)
                c[i] = 4'h0;
            {c[5], c[6]} = (kind == 2) ? swa : ~swa;
        end else
            c[1] = c[1] | 4'h1;
        if (kind == 2) begin
            {c[10], c[11]} = b0;
            {c[12], c[13]} = b1;
            {c[16], c[17]} = b3;
            for (int k = 0; k < n; k++)
                if (b0[0])
                    exp_rd.push_back(exp_regs[k]);
                else
                    exp_regs[k] = {c[18 + 2 * k], c[19 + 2 * k]};
        end else
            for (int i = 0; i < 106; i++)
                expq[p].push_back(c[i]);
        cyc(p, 1'b1, 4'($urandom));
        for (int i = 0; i < 106; i++)
            cyc(p, 1'b0, c[i]);
    endtask

    // keep the link clock running so delayed output drains
    task automatic flush(input bit p);
        repeat (12) cyc(p, 1'b0, 4'($urandom));
    endtask

    // one manager exchange driven by a control cell, tx traffic alongside
    task automatic exch(input bit rd, input logic [7:0] cnt, input logic [7:0] pl,
                        input bit twice);
        logic [7:0] b1;
        int         c0, w0, r0, d0, n;
        b1 = 8'($urandom);
        c0 = u_cpmb_ctrl_model.n_cmd;
        w0 = u_cpmb_ctrl_model.n_wr;
        r0 = u_cpmb_ctrl_model.n_rd;
        d0 = n_done;
        n = (cnt > 13) ? 13 : int'(cnt);
        ack_polls = pl;
        fork
            begin
                send(0, 2, {7'($urandom), rd}, b1, cnt);
                if (twice)
                    send(0, 2, 8'h01, 8'h00, 8'h00);
            end
            begin
                send(1, 0, 8'h00, 8'h00, 8'h00);
                flush(1);
            end
        join
        for (int i = 0; i < 4000 && n_done == d0; i++)
            @(negedge clk);
        `CHK("exchanges", d0 + 1, n_done)
        `CHK("busy", 1'b0, busy)
        `CHK("commands", c0 + 1, u_cpmb_ctrl_model.n_cmd)
        `CHK("command byte", b1, u_cpmb_ctrl_model.cmd)
        `CHK("data writes", rd ? 0 : n, u_cpmb_ctrl_model.n_wr - w0)
        `CHK("data reads", rd ? n : 0, u_cpmb_ctrl_model.n_rd - r0)
        `CHK("status polls", pl + 1, u_cpmb_ctrl_model.polls)
        for (int k = 0; k < 13; k++)
            `CHK("data register", exp_regs[k], u_cpmb_ctrl_model.regs[k])
    endtask

    // verdict and end of run
    task automatic summarize;
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial begin
        void'($urandom(32'h1c82e364));
        rst_n = 1'b0;
        lk_clk = 2'b00;
        lk_mark = 2'b00;
        lk_nib = '0;
        ack_polls = 8'h00;
        swa = 8'($urandom);
        repeat (2) @(negedge clk);
        `CHK("idle strobe", 1'b1, strb_n)
        `CHK("idle direction", 1'b1, dir)
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        // back-to-back plain cells both ways, one near miss on the address
        fork
            begin
                send(0, 0, 8'h00, 8'h00, 8'h00);
                send(0, 1, 8'h00, 8'h00, 8'h00);
                send(0, 0, 8'h00, 8'h00, 8'h00);
                flush(0);
            end
            begin
                repeat (3) send(1, 0, 8'h00, 8'h00, 8'h00);
                flush(1);
            end
        join
        // full write, long ack wait read, clamped count, command only
        exch(1'b0, 8'd13, 8'd0, 1'b0);
        exch(1'b1, 8'd5, 8'd34, 1'b0);
        exch(1'b0, 8'd20, 8'd1, 1'b0);
        exch(1'b0, 8'd0, 8'd0, 1'b0);
        repeat (3) exch(1'($urandom), 8'($urandom_range(13)), 8'($urandom_range(6)), 1'b0);
        // second control cell while busy is dropped
        exch(1'b0, 8'd2, 8'd80, 1'b1);
        `CHK("rx cells left", 0, expq[0].size())
        `CHK("tx cells left", 0, expq[1].size())
        `CHK("reads left", 0, exp_rd.size())
        `CHK("bus slips", 0, u_cpmb_ctrl_model.err_cnt)
        summarize;
    end

    // watchdog against a hang
    initial begin
        #1000000;
        n_fail++;
        summarize;
    end
endmodule

// file: verif/cpmb_ctrl_model.sv
// Purpose: behavioural switch controller on the manager bus
// Assumes: 50 ns controller clock, strobe active low
// Notes:   protocol slips are counted in err_cnt
module cpmb_ctrl_model (
    input  wire logic       reset_n_in,
    input  wire logic       strobe_n_in,
    input  wire logic       dir_in,
    input  wire logic       sel_in,
    input  wire logic [7:0] dev_data_in,
    input  wire logic       dev_oe_in,
    input  wire logic [7:0] ack_polls_in,
    output logic [7:0]      bus_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] regs [13];
    logic [7:0] cmd, fall_data, fall_rd, rd_val;
    logic [7:0] last     = 8'h00;
    logic [3:0] idx      = 4'h0;
    logic       ack_seen = 1'b1;
    logic       ddir     = 1'b0;
    logic       fall_sel, fall_dir;
    int         n_cmd, n_wr, n_rd, polls, err_cnt;
    realtime    t_rise   = 0;
    assign rd_val = sel_in ? regs[idx] : {polls >= int'(ack_polls_in), 7'h15};
    assign bus_out = dev_oe_in ? dev_data_in : (!strobe_n_in && dir_in) ? rd_val : ~last;
    // capture lines at strobe fall
    always @(negedge strobe_n_in) begin
        fall_sel = sel_in;
        fall_dir = dir_in;
        fall_data = dev_data_in;
        fall_rd = rd_val;
        if (reset_n_in && dev_oe_in && dir_in)
            err_cnt++;
    end
    // access takes effect at strobe rise
    always @(posedge strobe_n_in) begin
        if (reset_n_in) begin
            t_rise = $realtime;
            last = dir_in ? fall_rd : dev_data_in;
            if (sel_in !== fall_sel || dir_in !== fall_dir || (!dir_in && dev_data_in !== fall_data))
                err_cnt++;
            if (!sel_in && !dir_in) begin
                if (!ack_seen)
                    err_cnt++;
                cmd = dev_data_in;
                n_cmd++;
                polls = 0;
                idx = 4'h0;
                ack_seen = 1'b0;
            end else if (!sel_in) begin
                ack_seen = ack_seen | fall_rd[7];
                polls++;
                idx = 4'h0;
            end else begin
                // writes after reads restart at register zero
                if (dir_in !== ddir)
                    idx = 4'h0;
                ddir = dir_in;
                if (!dir_in)
                    regs[idx] = dev_data_in;
                n_wr += int'(!dir_in);
                n_rd += int'(dir_in);
                idx++;
            end
        end
    end
    always @(sel_in or dir_in) begin
        if (reset_n_in && t_rise > 0 && $realtime - t_rise < 100.0)
            err_cnt++;
    end
endmodule
